// ==== rtl/receiver_mode_control_decode.sv ====
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "rmc_cfg.svh"
// Function
// R1 - Auto-poll bit low keeps the receiver awake, high makes it cycle sleep and wake-up polling.
// R2 - The demodulator speed bit resets to 0 (normal bandwidths); 1 asks for an unavailable fast set.
// R3 - Muting is enabled when the mute pin equals the polarity bit and disabled otherwise.
// R4 - An undriven mute pin reads high, so the default polarity leaves muting off.
// R5 - With the watchdog enabled its timeout is 20, 5, 10 or 5 ms for bandwidth bits 00, 01, 10, 11.
// R6 - With the watchdog disabled the receiver keeps checking bits with no time limit.
// R7 - The top bit gives no signal-strength offset at 0 and a +200 mV offset at 1.
// R8 - The top bit at 0 enables fast-attack gain control and threshold hold; at 1 disables both.
// R9 - The two bandwidth pins select 1625, 3250, 6500 or 13000 Hz, open pins reading as 1.
// R10 - Output is muted at four or fewer good of eight bits and unmuted at seven or more.
// R11 - Sleep time is 10 ms doubled per step of the three-bit code, default code giving 40 ms.
// R12 - Bit-check count codes 00, 01, 10, 11 require 0, 2, 4 and 8 good bits before data flows.
// R13 - In auto-poll bit-checking, an expired watchdog with no transitions returns the receiver to sleep.
// R14 - All configuration takes its default at reset and holds until rewritten.
module receiver_mode_control_decode #(
  parameter int unsigned SLEEP_BASE_CYC = `RMC_SLEEP_MS * `RMC_CLK_MHZ * 1000,
  parameter int unsigned WD_LONG_CYC    = `RMC_WD_LONG_MS * `RMC_CLK_MHZ * 1000,
  parameter int unsigned WD_MID_CYC     = `RMC_WD_MID_MS * `RMC_CLK_MHZ * 1000,
  parameter int unsigned WD_SHORT_CYC   = `RMC_WD_SHORT_MS * `RMC_CLK_MHZ * 1000
) (
  // Clock and shutdown reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_arst_n,
  // Register port
  input  wire logic [`RMC_ADDR_W-1:0]   i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [31:0]              o_rdata,
  // Configuration pins
  input  wire logic                     i_mute_control_pin,
  input  wire logic                     i_mute_pin_driven,
  input  wire logic                     i_bw_choice_pin0,
  input  wire logic                     i_bw_choice_pin1,
  // Bit-check events
  input  wire rmc_pkg::bit_evt_t        i_evt,
  // Decoded controls
  output logic                          o_rx_awake,
  output logic                          o_data_mute,
  output logic                          o_demod_fast,
  output logic                          o_rssi_offset_on,
  output logic                          o_fast_agc_en,
  output logic      [1:0]               o_bw_sel,
  output rmc_pkg::poll_state_t          o_poll_state
);
  import rmc_pkg::*;

  rmc_state_t r;
  rmc_state_t r_nxt;
  logic       mute_pin_eff;
  logic       mute_en;
  logic [3:0] good_cnt;
  logic [3:0] check_target;
  logic [31:0] wd_load;
  logic [31:0] sleep_load;

  // ----------------------------------------------------------------------
  // Pin and field decode
  // ----------------------------------------------------------------------
  // Internal pull-up: an undriven pin reads high
  assign mute_pin_eff = i_mute_pin_driven ? i_mute_control_pin : 1'b1; // R4
  assign mute_en      = (mute_pin_eff == r.ctrl[`RMC_F_MUTEPOL]);       // R3
  assign good_cnt     = 4'($countones(r.hist));
  assign sleep_load   = SLEEP_BASE_CYC << r.ctrl[`RMC_F_SLP0 +: 3];     // R11

  // Good-bit target from the two count bits
  always_comb begin
    unique case ({r.ctrl[`RMC_F_BC1], r.ctrl[`RMC_F_BC0]})
      2'b00: check_target = 4'h0; // R12
      2'b01: check_target = 4'h2; // R12
      2'b10: check_target = 4'h4; // R12
      2'b11: check_target = 4'h8; // R12
    endcase
  end

  // Watchdog length follows the bandwidth bits, first bit listed first
  always_comb begin
    unique case ({r.ctrl[`RMC_F_BW_LO], r.ctrl[`RMC_F_BW_HI]})
      2'b00: wd_load = WD_LONG_CYC;  // R5
      2'b01: wd_load = WD_SHORT_CYC; // R5
      2'b10: wd_load = WD_MID_CYC;   // R5
      2'b11: wd_load = WD_SHORT_CYC; // R5
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    r_nxt.ap_prev = r.ctrl[`RMC_F_AUTOPOLL];
    // Register writes; holds otherwise
    if (i_wr && i_addr == `RMC_ADDR_CTRL) begin
      r_nxt.ctrl = i_wdata[`RMC_CTRL_W-1:0]; // R14
    end
    // Read data valid only in the cycle after the strobe
    r_nxt.rdata = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr == `RMC_ADDR_CTRL) begin
        r_nxt.rdata = {12'h000, r.ctrl};
      end else if (i_addr == `RMC_ADDR_STAT) begin
        r_nxt.rdata = {16'h0000, r.hist, r.good, r.awake, r.mute, r.state};
      end
    end
    // Static decodes, one cycle behind the control word, or behind the bandwidth pins for bw
    r_nxt.speed    = r.ctrl[`RMC_F_SPEED];     // R2
    r_nxt.rssi     = r.ctrl[`RMC_F_RSSI];      // R7
    r_nxt.fast_agc = ~r.ctrl[`RMC_F_RSSI];     // R8
    r_nxt.bw       = {i_bw_choice_pin1, i_bw_choice_pin0}; // R9
    // Squelch history of the last eight checked bits
    if (i_evt.good || i_evt.bad) begin
      r_nxt.hist = {r.hist[6:0], i_evt.good};
    end
    // Hysteresis keeps the output from chattering between limits
    if (!mute_en) begin
      r_nxt.mute = 1'b0; // R3
    end else if (good_cnt >= 4'(`RMC_GOOD_ON)) begin
      r_nxt.mute = 1'b0; // R10
    end else if (good_cnt <= 4'(`RMC_GOOD_OFF)) begin
      r_nxt.mute = 1'b1; // R10
    end
    // Poll sequencer
    if (!r.ctrl[`RMC_F_AUTOPOLL]) begin
      r_nxt.state = ST_AWAKE; // R1
    end else if (!r.ap_prev) begin
      // Fresh enable starts a sleep period
      r_nxt.state = ST_SLEEP; // R1
      r_nxt.tmr   = sleep_load;
    end else begin
      unique case (r.state)
        ST_AWAKE: begin
          r_nxt.state = ST_AWAKE;
        end
        ST_SLEEP: begin
          if (r.tmr <= 32'd1) begin
            r_nxt.good = 4'h0;
            r_nxt.wdog = wd_load;
            r_nxt.state = (check_target == 4'h0) ? ST_AWAKE : ST_CHECK; // R11
          end else begin
            r_nxt.tmr = r.tmr - 32'd1;
          end
        end
        ST_CHECK: begin
          r_nxt.wdog = (i_evt.edge_seen || i_evt.good || i_evt.bad) ? wd_load : r.wdog - 32'd1;
          if (i_evt.bad) begin
            r_nxt.state = ST_SLEEP;
            r_nxt.tmr   = sleep_load;
          end else if (i_evt.good && (r.good + 4'h1 >= check_target)) begin
            r_nxt.state = ST_AWAKE; // R12
          end else if (i_evt.good) begin
            r_nxt.good = r.good + 4'h1;
          end else if (!r.ctrl[`RMC_F_WDOG_DIS] && r.wdog <= 32'd1 && !i_evt.edge_seen) begin
            r_nxt.state = ST_SLEEP; // R13
            r_nxt.tmr   = sleep_load;
          end
          // Disabled watchdog never ends the check period
          if (r.ctrl[`RMC_F_WDOG_DIS]) begin
            r_nxt.wdog = wd_load; // R6
          end
        end
      endcase
    end
    r_nxt.awake = (r_nxt.state == ST_AWAKE);
  end

  // ----------------------------------------------------------------------
  // State register; shutdown restores every default
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r          <= '0;
      r.ctrl     <= `RMC_CTRL_RST; // R14
      r.state    <= ST_AWAKE;
      r.awake    <= 1'b1;
      r.fast_agc <= 1'b1;
      r.bw       <= 2'b11;
    end else begin
      r <= r_nxt;
    end
  end

  // Outputs straight from the state flops
  assign o_rdata          = r.rdata;
  assign o_rx_awake       = r.awake;
  assign o_data_mute      = r.mute;
  assign o_demod_fast     = r.speed;
  assign o_rssi_offset_on = r.rssi;
  assign o_fast_agc_en    = r.fast_agc;
  assign o_bw_sel         = r.bw;
  assign o_poll_state     = r.state;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_no_poll_awake: assert property (!r.ctrl[`RMC_F_AUTOPOLL] |=> r.state == ST_AWAKE && o_rx_awake) // R1
    else $error("not awake with auto-poll off");
  a_speed_follows: assert property (i_wr && i_addr == `RMC_ADDR_CTRL // R2
      |=> ##1 o_demod_fast == $past(i_wdata[`RMC_F_SPEED], 2))
    else $error("speed select not decoded");
  a_mute_differs: assert property (mute_pin_eff != r.ctrl[`RMC_F_MUTEPOL] |=> !o_data_mute) // R3
    else $error("mute active while disabled");
  a_pullup_default: assert property (!i_mute_pin_driven && !r.ctrl[`RMC_F_MUTEPOL] |=> !o_data_mute) // R4
    else $error("floating pin did not disable mute");
  a_wdog_expire: assert property (r.state == ST_CHECK && r.ap_prev && r.ctrl[`RMC_F_AUTOPOLL] // R13
      && !r.ctrl[`RMC_F_WDOG_DIS] && r.wdog == 32'd1 && i_evt == '0 |=> r.state == ST_SLEEP)
    else $error("watchdog expiry did not sleep");
  a_wdog_disabled: assert property (r.state == ST_CHECK && r.ctrl[`RMC_F_WDOG_DIS] && !i_evt.bad // R6
      |=> r.state != ST_SLEEP)
    else $error("disabled watchdog forced sleep");
  a_rssi_offset: assert property (i_wr && i_addr == `RMC_ADDR_CTRL // R7
      |=> ##1 o_rssi_offset_on == $past(i_wdata[`RMC_F_RSSI], 2))
    else $error("rssi offset not decoded");
  a_fast_agc: assert property (o_fast_agc_en == !o_rssi_offset_on) // R8
    else $error("fast agc does not mirror top bit");
  a_bw_pins: assert property (1'b1 |=> o_bw_sel == $past({i_bw_choice_pin1, i_bw_choice_pin0})) // R9
    else $error("bandwidth pins not followed");
  a_squelch_open: assert property (good_cnt >= 4'(`RMC_GOOD_ON) |=> !o_data_mute) // R10
    else $error("seven good bits left output muted");
  a_squelch_shut: assert property (mute_en && good_cnt <= 4'(`RMC_GOOD_OFF) |=> o_data_mute) // R10
    else $error("four good bits left output open");
  a_sleep_end: assert property (r.state == ST_SLEEP && r.ap_prev && r.ctrl[`RMC_F_AUTOPOLL] // R11
      && r.tmr == 32'd1 |=> r.state != ST_SLEEP)
    else $error("sleep did not end on time");
  a_check_done: assert property (r.state == ST_CHECK && r.ap_prev && r.ctrl[`RMC_F_AUTOPOLL] // R12
      && i_evt.good && !i_evt.bad && r.good + 4'h1 == check_target |=> r.state == ST_AWAKE)
    else $error("enough good bits did not wake");
  a_ctrl_hold: assert property (!(i_wr && i_addr == `RMC_ADDR_CTRL) |=> $stable(r.ctrl)) // R14
    else $error("control word changed without write");

  c_enter_check: cover property (r.state == ST_SLEEP ##1 r.state == ST_CHECK);
  c_wake_check:  cover property (r.state == ST_CHECK ##1 r.state == ST_AWAKE);
  c_unmute:      cover property (o_data_mute ##1 !o_data_mute);
  c_wdog_sleep:  cover property (r.state == ST_CHECK ##1 r.state == ST_SLEEP);
endmodule

// ==== rtl/rmc_cfg.svh ====
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH
// ----------------------------------------------------------------------
// Register map and field positions
// ----------------------------------------------------------------------
`define RMC_ADDR_W       4
`define RMC_ADDR_CTRL    4'h0
`define RMC_ADDR_STAT    4'h4
`define RMC_CTRL_W       20
`define RMC_CTRL_RST     20'h02E78
`define RMC_F_BW_LO      3
`define RMC_F_BW_HI      4
`define RMC_F_BC0        7
`define RMC_F_BC1        8
`define RMC_F_SLP0       12
`define RMC_F_AUTOPOLL   15
`define RMC_F_SPEED      16
`define RMC_F_MUTEPOL    17
`define RMC_F_WDOG_DIS   18
`define RMC_F_RSSI       19
// ----------------------------------------------------------------------
// Timing and squelch thresholds
// ----------------------------------------------------------------------
`define RMC_CLK_MHZ      20
`define RMC_SLEEP_MS     10
`define RMC_WD_LONG_MS   20
`define RMC_WD_MID_MS    10
`define RMC_WD_SHORT_MS  5
`define RMC_GOOD_ON      7
`define RMC_GOOD_OFF     4
`endif

// ==== rtl/rmc_pkg.sv ====
package rmc_pkg;
  typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_CHECK} poll_state_t;

  // Bit-check results from the window timer
  typedef struct packed {
    logic good;
    logic bad;
    logic edge_seen;
  } bit_evt_t;

  // Complete block state
  typedef struct packed {
    logic [19:0] ctrl;
    poll_state_t state;
    logic [31:0] tmr;
    logic [31:0] wdog;
    logic [3:0]  good;
    logic [7:0]  hist;
    logic        mute;
    logic        awake;
    logic        speed;
    logic        rssi;
    logic        fast_agc;
    logic [1:0]  bw;
    logic        ap_prev;
    logic [31:0] rdata;
  } rmc_state_t;
endpackage

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
`include "rmc_cfg.svh"
// ------------------------------------------------
// Host model: register bus master and mute pin
// ------------------------------------------------
module host_model (
  // Clock
  input  wire logic                   i_sys_clk,
  // Register port toward the block
  output logic      [`RMC_ADDR_W-1:0] o_addr,
  output logic      [31:0]            o_wdata,
  output logic                        o_wr,
  output logic                        o_rd,
  input  wire logic [31:0]            i_rdata,
  // Mute pin intent from the bench
  input  wire logic                   i_sq_drive,
  input  wire logic                   i_sq_level,
  // Resolved mute pin
  output logic                        o_mute_pin,
  output logic                        o_mute_driven
);
  // Pull-up wins once the host lets go
  assign o_mute_pin    = i_sq_drive ? i_sq_level : 1'b1;
  assign o_mute_driven = i_sq_drive;

  // Idle bus from time zero
  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // One-cycle write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_sys_clk);
    o_rd   <= 1'b0;
    @(negedge i_sys_clk);
    d = i_rdata;
  endtask
endmodule

// ==== testbench/receiver_mode_control_decode_tb_top.sv ====
`timescale 1ns/1ps
module receiver_mode_control_decode_tb_top;
  import rmc_pkg::*;
  // ------------------------------------------------
  // Wiring
  // ------------------------------------------------
  logic        clk, rst_n, sq_drv, sq_lvl, bw0, bw1, wr, rd, mpin, mdrv;
  logic        awake, mute, fast, rssi, agc;
  logic [3:0]  addr;
  logic [31:0] wd, rdat, got;
  logic [1:0]  bw;
  logic [19:0] w;
  bit_evt_t    evt;
  poll_state_t st;
  int          fails = 0, n_compared = 0, seed = 32'h247F, n, tgt;
  bit          sq_g[5] = '{0, 1, 1, 0, 0};
  int          sq_k[5] = '{8, 6, 1, 3, 1};
  bit          sq_m[5] = '{1, 1, 0, 0, 1};

  host_model HOST (.i_sys_clk(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd), .i_rdata(rdat),
    .i_sq_drive(sq_drv), .i_sq_level(sq_lvl), .o_mute_pin(mpin), .o_mute_driven(mdrv));
  // Short counts keep the run brief
  receiver_mode_control_decode #(.SLEEP_BASE_CYC(16), .WD_LONG_CYC(32), .WD_MID_CYC(16), .WD_SHORT_CYC(8)) DUT (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_mute_control_pin(mpin), .i_mute_pin_driven(mdrv), .i_bw_choice_pin0(bw0), .i_bw_choice_pin1(bw1),
    .i_evt(evt), .o_rx_awake(awake), .o_data_mute(mute), .o_demod_fast(fast), .o_rssi_offset_on(rssi),
    .o_fast_agc_en(agc), .o_bw_sel(bw), .o_poll_state(st));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Cycle counts must match exactly
  task automatic chk_n(input int g, input int e, input string m);
    n_compared++;
    if (g != e) begin
      fails++;
      $display("ERROR %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic count_in(input poll_state_t s, output int c);
    c = 0;
    while (st === s && c < 3000) begin
      @(negedge clk);
      c++;
    end
    // A stuck state counts as a mismatch and ends the run
    if (st === s) begin
      fails++;
      $display("ERROR %0t state stuck past wait limit", $time);
      complete_run;
    end
  endtask
  task automatic pulse(input logic g, input int k);
    repeat (k) @(posedge clk) evt <= '{good: g, bad: !g, edge_seen: 1'b1};
    @(posedge clk) evt <= '0;
    @(negedge clk);
  endtask
  // Clear, then set auto-poll and time the sleep
  task automatic enter_poll(input logic [19:0] c);
    int k;
    HOST.bus_wr(4'h0, {12'h0, c & ~20'h08000});
    HOST.bus_wr(4'h0, {12'h0, c | 20'h08000});
    for (k = 0; k < 20 && st !== ST_SLEEP; k++) @(negedge clk);
    chk(32'({awake, st}), 32'({1'b0, ST_SLEEP}), "sleep entry");
    if (st !== ST_SLEEP) complete_run;
    count_in(ST_SLEEP, n);
    chk_n(n, 16 << c[14:12], "sleep time");
  endtask
  function automatic int wd_cyc(input int i);
    return i == 0 ? 32 : (i == 1 ? 16 : 8);
  endfunction

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    rst_n = 1'b0;
    sq_drv = 1'b0;
    sq_lvl = 1'b0;
    {bw1, bw0} = 2'b11;
    evt = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'({awake, fast, rssi, agc, st}), 32'({4'b1001, ST_AWAKE}), "reset outputs");
    HOST.bus_rd(4'h0, got);
    chk(got, 32'h0002E78, "ctrl default");
    HOST.bus_rd(4'h4, got);
    chk(got, 32'h00000008, "status default");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {bw1, bw0} <= 2'(i);
      settle;
      chk(32'(bw), 32'(i), "bw pins");
    end
    // Random words, a status write and an unmapped read
    repeat (12) begin
      w = 20'($random(seed)) & ~20'h08000;
      HOST.bus_wr(4'h0, {12'($random(seed)), w});
      HOST.bus_wr(4'h4, $random(seed));
      HOST.bus_rd(4'h0, got);
      chk(got, {12'h0, w}, "ctrl readback");
      chk(32'({fast, rssi, agc}), 32'({w[16], w[19], ~w[19]}), "decoded");
      HOST.bus_rd(4'h8, got);
      chk(got, 32'h0, "unmapped");
    end
    // Pin and polarity table, last pass with pin floating
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) sq_drv <= (i < 4);
      @(posedge clk) sq_lvl <= i[0];
      HOST.bus_wr(4'h0, 32'(i[1]) << 17);
      pulse(1'b0, 8);
      @(negedge clk);
      chk(32'(mute), 32'(((i < 4) ? i[0] : 1'b1) == i[1]), "mute enable");
    end
    HOST.bus_wr(4'h0, 32'h20000);
    foreach (sq_g[j]) begin
      pulse(sq_g[j], sq_k[j]);
      @(negedge clk);
      chk(32'(mute), 32'(sq_m[j]), "squelch count");
    end
    // Every bit-check count with a random sleep code
    for (int i = 0; i < 4; i++) begin
      w = {5'h0, 3'($random(seed)), 3'h0, i[1], i[0], 7'h0};
      tgt = (i == 0) ? 0 : 2 << (i - 1);
      enter_poll(w);
      if (tgt > 0) begin
        pulse(1'b1, tgt - 1);
        chk(32'(st), 32'(ST_CHECK), "too few good");
        pulse(1'b1, 1);
      end
      chk(32'({awake, st}), 32'({1'b1, ST_AWAKE}), "wake on count");
    end
    // Watchdog timeout per bandwidth code
    for (int i = 0; i < 4; i++) begin
      enter_poll(20'h00080 | (20'(i) << 3));
      count_in(ST_CHECK, n);
      chk_n(n, wd_cyc(i), "watchdog");
      chk(32'(st), 32'(ST_SLEEP), "resleep");
    end
    // Bare transitions keep reloading the watchdog
    enter_poll(20'h00080);
    repeat (3) begin
      repeat (20) @(posedge clk);
      evt <= '{good: 1'b0, bad: 1'b0, edge_seen: 1'b1};
      @(posedge clk) evt <= '0;
    end
    @(negedge clk);
    chk(32'(st), 32'(ST_CHECK), "edge reload");
    enter_poll(20'h40080);
    repeat (100) @(negedge clk);
    chk(32'(st), 32'(ST_CHECK), "no watchdog");
    pulse(1'b0, 1);
    chk(32'(st), 32'(ST_SLEEP), "bad bit");
    HOST.bus_wr(4'h0, 32'h0);
    settle;
    chk(32'({awake, st}), 32'({1'b1, ST_AWAKE}), "poll off");
    // Shutdown in mid-run restores every default
    HOST.bus_wr(4'h0, 32'h000FFFFF);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'({awake, fast, rssi, agc, st}), 32'({4'b1001, ST_AWAKE}), "shutdown outputs");
    HOST.bus_rd(4'h0, got);
    chk(got, 32'h0002E78, "ctrl after shutdown");
    complete_run;
  end
endmodule
